/* File: rtl/scpm_cfg.svh */
`ifndef SCPM_CFG_SVH
`define SCPM_CFG_SVH
// Strap code widths and table sizes
`define SCPM_CODE_W       4
`define SCPM_BOOT_CODES   10
`define SCPM_ADDR_CODES   8
`define SCPM_FREQ_CODES   10
// Rail bus addresses
`define SCPM_ADDR_A0      8'h00
`define SCPM_ADDR_A1      8'h01
`define SCPM_ADDR_S0      8'h02
`define SCPM_ADDR_S1      8'h03
// Boot voltage codes (millivolts)
`define SCPM_MV_0         12'h000
`define SCPM_MV_800       12'h320
`define SCPM_MV_950       12'h3B6
`define SCPM_MV_1050      12'h41A
// Phase limits
`define SCPM_MAX_PHASES   2'h2
// System power readback register
`define SCPM_SYSPWR_REG   8'h0D
// Strap source current (microamps), informational for the measurement unit
`define SCPM_STRAP_UA     10
// Number of strap pins
`define SCPM_STRAP_PINS   4
`endif

/* File: rtl/scpm_pkg.sv */
package scpm_pkg;
	// Power state command
	typedef enum logic [2:0] {
		PS_FULL  = 3'h0,
		PS_LIGHT = 3'h1,
		PS_LOW   = 3'h2,
		PS_LOWER = 3'h3,
		PS_OFF   = 3'h4
	} scpm_pstate_t;
	// Rail operating mode, one-hot
	typedef enum logic [3:0] {
		MODE_MULTI = 4'b0001,
		MODE_CCM   = 4'b0010,
		MODE_DCM   = 4'b0100,
		MODE_OFF   = 4'b1000
	} scpm_mode_t;
	// Loader sequence states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_MEAS = 4'b0010,
		ST_DEC  = 4'b0100,
		ST_DONE = 4'b1000
	} scpm_state_t;
endpackage : scpm_pkg

/* File: rtl/scpm_boot_decode.sv */
`timescale 1ns/1ns
`include "scpm_cfg.svh"
// Boot strap code to voltages and doubler select
module scpm_boot_decode
	import scpm_pkg::*;
(
	input  wire logic [3:0]  code,       // Boot strap setting 0..9
	output logic      [11:0] bootMvA,    // Rail A boot millivolts
	output logic      [11:0] bootMvB,    // Rail B boot millivolts
	output logic      [11:0] bootMvS,    // Single rail boot millivolts
	output logic             doublerEn,  // Rail A phase doubling
	output logic             codeOk      // Code inside the table
);
	wire highPair = (code == 4'h8) || (code == 4'h9);
	wire [1:0] pairIdx = code[2:1];

	// Multi-phase rails only boot in the top two settings
	assign bootMvA = highPair ? `SCPM_MV_1050 : `SCPM_MV_0;
	assign bootMvB = bootMvA;

	// Single rail by pair of settings
	assign bootMvS = highPair ? `SCPM_MV_1050 :
		(pairIdx == 2'h0) ? `SCPM_MV_0 :
		(pairIdx == 2'h1) ? `SCPM_MV_1050 :
		(pairIdx == 2'h2) ? `SCPM_MV_950 : `SCPM_MV_800;

	// Even settings counting from one have odd zero-based codes
	assign doublerEn = code[0];
	assign codeOk    = code < 4'hA;
endmodule : scpm_boot_decode

/* File: rtl/scpm_strap_loader.sv */
`timescale 1ns/1ns
`include "scpm_cfg.svh"
module scpm_strap_loader
	import scpm_pkg::*;
(
	input  wire logic        clk_sys,       // System clock 125 MHz
	input  wire logic        reset,         // Async reset, active high
	input  wire logic        startLoad,     // Begin power-up strap load
	output logic             measReq,       // Request strap measurement
	input  wire logic        measDone,      // Converter readings ready
	input  wire logic [3:0]  codeBoot,      // Boot strap setting
	input  wire logic [3:0]  codeAddr,      // Address strap setting
	input  wire logic [3:0]  codeFreqMulti, // Multi-phase freq setting
	input  wire logic [3:0]  codeFreqSingle,// Single rail freq setting
	input  wire logic [2:0]  powerState,    // Commanded power state
	input  wire logic [7:0]  regAddr,       // Bus register address
	input  wire logic [7:0]  sysPowerMeas,  // Measured system power
	output logic [7:0]       regRdData,     // Readback data
	output logic             regRdHit,      // Address is system power
	output logic [7:0]       addrRailA_ff,  // Rail A bus address
	output logic [7:0]       addrRailB_ff,  // Rail B bus address
	output logic [7:0]       addrRailS_ff,  // Single rail bus address
	output logic             pinIsSysPwr_ff,// Shared pin is power input
	output logic [1:0]       maxPhasesA_ff, // Rail A phase limit
	output logic [1:0]       maxPhasesB_ff, // Rail B phase limit
	output logic [11:0]      bootMvA_ff,    // Rail A boot millivolts
	output logic [11:0]      bootMvB_ff,    // Rail B boot millivolts
	output logic [11:0]      bootMvS_ff,    // Single rail boot millivolts
	output logic             doublerEn_ff,  // Rail A phase doubler on
	output logic [3:0]       freqMulti_ff,  // Shared multi-phase freq code
	output logic [3:0]       freqSingle_ff, // Single rail freq code
	output logic             cfgValid_ff,   // All straps decoded
	output logic             cfgError_ff,   // A strap code out of range
	output scpm_mode_t       modeRails_ff,  // Two-phase rail mode
	output logic [1:0]       activePh_ff    // Active phases per rail
);
	scpm_state_t state_ff;
	scpm_state_t nxt_state;
	logic [11:0] decMvA;
	logic [11:0] decMvB;
	logic [11:0] decMvS;
	logic        decDbl;
	logic        bootOk;
	// Codes copied on the measDone edge
	logic [3:0]  capBoot_ff;    // Boot code held from measDone
	logic [3:0]  capAddr_ff;    // Address code held from measDone
	logic [3:0]  capFreqM_ff;   // Multi freq code held
	logic [3:0]  capFreqS_ff;   // Single freq code held

	// Boot strap table, fed from the held code so that the latch does not
	// see the converter lines after they have gone stale
	scpm_boot_decode uBoot (
		.code      (capBoot_ff),
		.bootMvA   (decMvA),
		.bootMvB   (decMvB),
		.bootMvS   (decMvS),
		.doublerEn (decDbl),
		.codeOk    (bootOk)
	);

	// Address strap decode from the held code
	// Bit 1 swaps the two multi-phase addresses, bit 0 picks the single
	// rail address and with it the job of the shared sense pin
	// Address rows above seven set the error flag
	wire       addrOk   = capAddr_ff < 4'h8;
	wire       swapAB   = capAddr_ff[1];
	wire [7:0] decAddrA = swapAB ? `SCPM_ADDR_A1 : `SCPM_ADDR_A0;
	wire [7:0] decAddrB = swapAB ? `SCPM_ADDR_A0 : `SCPM_ADDR_A1;
	wire [7:0] decAddrS = capAddr_ff[0] ? `SCPM_ADDR_S1 :
		`SCPM_ADDR_S0;
	wire       decSysPw = ~capAddr_ff[0];
	// Out-of-range frequency codes are passed on but flagged
	wire       freqOk   = (capFreqM_ff < 4'hA) && (capFreqS_ff < 4'hA);
	wire       allOk    = bootOk && addrOk && freqOk;

	// Sequencer controls
	// measReq is decoded straight from the state, no extra flop
	wire inMeas   = state_ff == ST_MEAS;
	wire doLatch  = state_ff == ST_DEC;
	assign measReq = inMeas;

	// The converter only vouches for its codes while measDone is high, so
	// they are copied on that edge and decoded one cycle later
	wire takeCodes = inMeas && measDone;

	// Held codes, cleared with everything else
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			capBoot_ff  <= 4'h0;
			capAddr_ff  <= 4'h0;
			capFreqM_ff <= 4'h0;
			capFreqS_ff <= 4'h0;
		end else if (takeCodes) begin
			capBoot_ff  <= codeBoot;
			capAddr_ff  <= codeAddr;
			capFreqM_ff <= codeFreqMulti;
			capFreqS_ff <= codeFreqSingle;
		end
	end

	// Next state: one load per reset, then frozen
	// DONE has no way out but reset, which is what keeps the boot
	// selection fixed once the first load has been taken
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: if (startLoad) nxt_state = ST_MEAS;
			ST_MEAS: if (measDone) nxt_state = ST_DEC;
			ST_DEC:  nxt_state = ST_DONE;
			ST_DONE: nxt_state = ST_DONE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) state_ff <= ST_IDLE;
		else       state_ff <= nxt_state;
	end

	// Address and pin function latch, reset gives 00h/01h/02h
	// Both multi-phase rails always allow two phases in this build
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			addrRailA_ff   <= `SCPM_ADDR_A0;
			addrRailB_ff   <= `SCPM_ADDR_A1;
			addrRailS_ff   <= `SCPM_ADDR_S0;
			pinIsSysPwr_ff <= 1'b1;
			maxPhasesA_ff  <= `SCPM_MAX_PHASES;
			maxPhasesB_ff  <= `SCPM_MAX_PHASES;
		end else if (doLatch) begin
			addrRailA_ff   <= decAddrA;
			addrRailB_ff   <= decAddrB;
			addrRailS_ff   <= decAddrS;
			pinIsSysPwr_ff <= decSysPw;
			maxPhasesA_ff  <= `SCPM_MAX_PHASES;
			maxPhasesB_ff  <= `SCPM_MAX_PHASES;
		end
	end

	// Boot voltages, defaults follow the reset addresses
	// Before the first load the single rail sits at 02h and so boots at
	// 1.05 V, while both multi-phase rails stay at 0 V
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bootMvA_ff   <= `SCPM_MV_0;
			bootMvB_ff   <= `SCPM_MV_0;
			bootMvS_ff   <= `SCPM_MV_1050;
			doublerEn_ff <= 1'b0;
		end else if (doLatch) begin
			bootMvA_ff   <= decMvA;
			bootMvB_ff   <= decMvB;
			bootMvS_ff   <= decMvS;
			doublerEn_ff <= decDbl;
		end
	end

	// Frequency codes: one shared, one independent
	// Rail A and rail B take the same code; the single rail has its own
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			freqMulti_ff  <= 4'h0;
			freqSingle_ff <= 4'h0;
		end else if (doLatch) begin
			freqMulti_ff  <= capFreqM_ff;
			freqSingle_ff <= capFreqS_ff;
		end
	end

	// Valid and error flags
	// A bad code still latches so the rails come up in a known state; the
	// error flag tells the supervisor not to trust it
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cfgValid_ff <= 1'b0;
			cfgError_ff <= 1'b0;
		end else if (doLatch) begin
			cfgValid_ff <= 1'b1;
			cfgError_ff <= ~allOk;
		end
	end

	// Power state to rail mode
	// Codes above the deepest state are treated as off, the safe choice
	// Mode follows the command one cycle later and needs no load first
	wire isFull  = powerState == PS_FULL;
	wire isLight = powerState == PS_LIGHT;
	wire isDcm   = (powerState == PS_LOW) || (powerState == PS_LOWER);
	wire isOff   = ~(isFull | isLight | isDcm);
	wire [3:0] nxt_mode = isFull ? MODE_MULTI :
		isLight ? MODE_CCM :
		isDcm ? MODE_DCM : MODE_OFF;
	wire [1:0] nxt_ph = isFull ? `SCPM_MAX_PHASES :
		isOff ? 2'h0 : 2'h1;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			modeRails_ff <= MODE_OFF;
			activePh_ff  <= 2'h0;
		end else begin
			modeRails_ff <= scpm_mode_t'(nxt_mode);
			activePh_ff  <= nxt_ph;
		end
	end

	// System power readback decode
	// Only one register of the bus map lives here; other addresses read 0
	assign regRdHit  = regAddr == `SCPM_SYSPWR_REG;
	assign regRdData = regRdHit ? sysPowerMeas : 8'h00;
endmodule : scpm_strap_loader

/* File: sim/scpm_strap_model.sv */
`timescale 1ns/1ns
// Strap resistors and converter seen by the loader
module scpm_strap_model (
	input  wire logic       clk_sys,  // Clock
	input  wire logic       reset,    // Reset
	input  wire logic       measReq,  // Measure request
	input  wire logic [2:0] dly,      // Converter delay
	input  wire logic [3:0] selB,     // Boot row
	input  wire logic [3:0] selA,     // Address row
	input  wire logic [3:0] selM,     // Multi freq row
	input  wire logic [3:0] selS,     // Single freq row
	output logic            measDone, // Readings ready
	output logic [3:0]      cB,       // Boot code
	output logic [3:0]      cA,       // Address code
	output logic [3:0]      cM,       // Multi freq code
	output logic [3:0]      cS        // Single freq code
);
	logic [2:0] cntFf;
	// Readings valid only while measuring
	assign cB = measReq ? selB : ~selB;
	assign cA = measReq ? selA : ~selA;
	assign cM = measReq ? selM : ~selM;
	assign cS = measReq ? selS : ~selS;
	// Done pulse after a variable delay
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cntFf <= 3'h0;
			measDone <= 1'b0;
		end else begin
			measDone <= measReq && !measDone && cntFf == dly;
			cntFf <= (measReq && !measDone) ? cntFf + 3'h1 : 3'h0;
		end
	end
endmodule : scpm_strap_model

/* File: sim/scpm_strap_sva.sv */
`timescale 1ns/1ns
// Timing and decode checks on loader ports
module scpm_strap_sva
	import scpm_pkg::*;
(
	input wire logic        clk_sys,        // Clock
	input wire logic        reset,          // Reset
	input wire logic        measReq,        // Request
	input wire logic        measDone,       // Done
	input wire logic [3:0]  codeBoot,       // Boot code
	input wire logic [3:0]  codeAddr,       // Address code
	input wire logic [2:0]  powerState,     // State
	input wire logic [7:0]  regAddr,        // Reg address
	input wire logic [7:0]  sysPowerMeas,   // Power
	input wire logic [7:0]  regRdData,      // Read data
	input wire logic        regRdHit,       // Hit
	input wire logic [7:0]  addrRailS_ff,   // Single addr
	input wire logic        pinIsSysPwr_ff, // Pin use
	input wire logic [11:0] bootMvS_ff,     // Single boot
	input wire logic        doublerEn_ff,   // Doubler
	input wire logic        cfgValid_ff,    // Valid
	input wire scpm_mode_t  modeRails_ff,   // Mode
	input wire logic [1:0]  activePh_ff     // Phases
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire took = measReq && measDone;
	AST_FULL: assert property (
		!$past(reset) && powerState == 3'h0 |=>
		modeRails_ff == MODE_MULTI && activePh_ff == 2'h2)
		else $error("full mode wrong");
	AST_LIGHT: assert property (
		!$past(reset) && powerState == 3'h1 |=>
		modeRails_ff == MODE_CCM && activePh_ff == 2'h1)
		else $error("light mode wrong");
	AST_DCM: assert property (
		!$past(reset) && powerState inside {3'h2, 3'h3} |=>
		modeRails_ff == MODE_DCM)
		else $error("dcm mode wrong");
	AST_OFF: assert property (
		powerState == 3'h4 |=> modeRails_ff == MODE_OFF && activePh_ff == 2'h0)
		else $error("off mode wrong");
	AST_VALID: assert property (
		took |-> !cfgValid_ff ##2 cfgValid_ff) else $error("valid late");
	AST_DBL: assert property (
		took |-> ##2 doublerEn_ff == $past(codeBoot[0], 2)) else $error("doubler");
	AST_ADDRS: assert property (
		took |-> ##2 addrRailS_ff[0] == $past(codeAddr[0], 2)
		&& pinIsSysPwr_ff != addrRailS_ff[0]) else $error("single addr");
	AST_FROZEN: assert property (
		cfgValid_ff |=> $stable(bootMvS_ff) && $stable(doublerEn_ff))
		else $error("boot changed");
	AST_READ: assert property (
		regRdHit == (regAddr == 8'h0D) && (!regRdHit || regRdData == sysPowerMeas))
		else $error("readback wrong");
	COV_LOAD: cover property (took ##2 cfgValid_ff);
	COV_OFF: cover property (powerState == 3'h4);
	COV_HIT: cover property (regRdHit);
endmodule : scpm_strap_sva
bind scpm_strap_loader scpm_strap_sva u_sva (
	.clk_sys(clk_sys), .reset(reset), .measReq(measReq),
	.measDone(measDone), .codeBoot(codeBoot), .codeAddr(codeAddr),
	.powerState(powerState), .regAddr(regAddr),
	.sysPowerMeas(sysPowerMeas), .regRdData(regRdData),
	.regRdHit(regRdHit), .addrRailS_ff(addrRailS_ff),
	.pinIsSysPwr_ff(pinIsSysPwr_ff), .bootMvS_ff(bootMvS_ff),
	.doublerEn_ff(doublerEn_ff), .cfgValid_ff(cfgValid_ff),
	.modeRails_ff(modeRails_ff), .activePh_ff(activePh_ff));

/* File: sim/scpm_strap_loader_bench.sv */
`timescale 1ns/1ns
// Loads every boot row once per reset and checks results
module scpm_strap_loader_bench;
	logic clk_sys = 0, reset = 1, startLoad = 0, measDone, measReq, rdHit;
	logic pinSys, dbl, valid, prevValid, cfgErr;
	logic [3:0]  selB = 0, selA = 0, selM = 0, selS = 0, cB, cA, cM, cS;
	logic [2:0]  powerState = 0, dly = 0;
	logic [7:0]  regAddr = 0, sysPowerMeas = 0, rdData, adA, adB, adS;
	logic [1:0]  phA, phB, actPh;
	logic [11:0] mvA, mvB, mvS;
	logic [3:0]  fM, fS, mode, mSel;
	logic [74:0] expQ[$];
	integer      seed = 59296, err_total = 0, checks_done = 0, i, k, n;
	scpm_strap_loader u_dut (.clk_sys(clk_sys), .reset(reset),
		.startLoad(startLoad), .measReq(measReq), .measDone(measDone),
		.codeBoot(cB), .codeAddr(cA), .codeFreqMulti(cM), .codeFreqSingle(cS),
		.powerState(powerState), .regAddr(regAddr), .sysPowerMeas(sysPowerMeas),
		.regRdData(rdData), .regRdHit(rdHit), .addrRailA_ff(adA),
		.addrRailB_ff(adB), .addrRailS_ff(adS), .pinIsSysPwr_ff(pinSys),
		.maxPhasesA_ff(phA), .maxPhasesB_ff(phB), .bootMvA_ff(mvA),
		.bootMvB_ff(mvB), .bootMvS_ff(mvS), .doublerEn_ff(dbl),
		.freqMulti_ff(fM), .freqSingle_ff(fS), .cfgValid_ff(valid),
		.cfgError_ff(cfgErr), .modeRails_ff(mode), .activePh_ff(actPh));
	scpm_strap_model u_model (.clk_sys(clk_sys), .reset(reset),
		.measReq(measReq), .dly(dly), .selB(selB), .selA(selA), .selM(selM),
		.selS(selS), .measDone(measDone), .cB(cB), .cA(cA), .cM(cM), .cS(cS));
	// Expected latched settings for one set of rows
	function logic [74:0] expf(input logic [3:0] b, a, m, s);
		logic [11:0] v;
		logic        bad;
		v = b < 2 ? 12'h000 : b < 4 ? 12'h41A : b < 6 ? 12'h3B6
			: b < 8 ? 12'h320 : 12'h41A;
		bad = b > 9 || a > 7 || m > 9 || s > 9;
		expf = {{2{b > 7 ? 12'h41A : 12'h000}}, v, b[0], 7'h00, a[1],
			7'h00, !a[1], 7'h01, a[0], !a[0], 4'hA, m, s, bad};
	endfunction : expf
	task chk(input logic [74:0] e, input logic [74:0] a);
		checks_done++;
		if (a !== e) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, a, e);
		end
	endtask : chk
	task final_report;
		if (err_total == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	// Clock
	initial forever #4 clk_sys = ~clk_sys;
	// Result watcher pops the oldest note when valid rises
	always @(negedge clk_sys) begin
		if (valid === 1'b1 && prevValid !== 1'b1 && expQ.size() > 0)
			chk(expQ.pop_front(), {mvA, mvB, mvS, dbl, adA, adB, adS, pinSys,
				phA, phB, fM, fS, cfgErr});
		prevValid = valid;
	end
	// Stimulus
	initial begin
		for (i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			reset <= 1'b1;
			repeat (6) @(posedge clk_sys);
			@(negedge clk_sys);
			chk({12'h41A, 8'h02, 1'b0, 2'h0}, {mvS, adS, valid, actPh});
			@(posedge clk_sys);
			n = $random(seed);
			selB <= i[3:0];
			selA <= {1'b0, n[2:0]};
			mSel = (i == 9) ? 4'hC : i[3:0];
			selM <= mSel;
			selS <= 4'h9 - i[3:0];
			dly <= n[5:3];
			reset <= 1'b0;
			startLoad <= 1'b1;
			expQ.push_back(expf(i[3:0], {1'b0, n[2:0]}, mSel, 4'h9 - i[3:0]));
			for (k = 0; k < 40 && valid !== 1'b1; k++) @(posedge clk_sys);
			if (k == 40) begin
				err_total++;
				final_report;
			end
			for (k = 0; k < 12; k++) begin
				@(posedge clk_sys);
				n = $random(seed);
				powerState <= n[2:0];
				sysPowerMeas <= n[10:3];
				regAddr <= n[11] ? 8'h0D : n[19:12];
				@(negedge clk_sys);
				chk({regAddr == 8'h0D ? sysPowerMeas : 8'h00}, rdData);
			end
		end
		if (expQ.size() != 0) begin
			err_total++;
			$display("Error %0t: latched results missing", $time);
		end
		final_report;
	end
endmodule : scpm_strap_loader_bench
